/* File: nia_pkg.sv */
// Package of constants and types for the nested interrupt acceptance block.
package nia_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_MASK   = 12'h008;
  localparam logic [11:0] ADDR_STATE  = 12'h00C;

  // Control register fields.
  localparam int CTRL_IE_BIT = 0;

  // Status and mask register layout.
  localparam int EV_ACC_BIT  = 0;
  localparam int EV_REJ_BIT  = 1;
  localparam int EV_SW_BIT   = 2;
  localparam int EV_WIDTH    = 3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic       RST_IE   = 1'h0;
  localparam logic [2:0] RST_MASK = 3'h0;
  localparam logic [1:0] RST_ISP  = 2'h3;

  // Priority levels: level 0 is the highest, level 3 the lowest.
  localparam logic [1:0] PRIO_LVL3 = 2'h3;

  // ****************************************************************
  // Servicing state
  // ****************************************************************
  typedef enum logic [1:0] {
    NIA_IDLE    = 2'b00,
    NIA_SVC_MSK = 2'b01,
    NIA_SVC_SW  = 2'b10
  } nia_svc_t;

endpackage : nia_pkg

/* File: nia_sync.sv */
// Two-flop synchroniser for a single asynchronous level.
`timescale 1ns/1ps
`default_nettype none
module nia_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // Data
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;
  logic meta_d;
  logic q_d;

  always_comb begin
    meta_d = d_i;
    q_d    = meta_q;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_q <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_q <= meta_d;
      q_o    <= q_d;
    end
  end
endmodule : nia_sync
`default_nettype wire

/* File: nia_judge.sv */
// Combinational acceptance decision for one pending request.
`timescale 1ns/1ps
`default_nettype none
module nia_judge (
  // Current servicing context
  input  wire nia_pkg::nia_svc_t svc_i,
  input  wire logic [1:0]        in_service_priority_i,
  input  wire logic              global_interrupt_enable_i,
  // Request
  input  wire logic              mask_req_i,
  input  wire logic [1:0]        request_priority_level_i,
  input  wire logic              sw_req_i,
  // Decision
  output logic                   accept_mask_o,
  output logic                   accept_sw_o
);
  logic prio_ok;

  always_comb begin
    // A lower number is a higher priority, so a request passes when its level
    // does not exceed the in-service level.
    prio_ok = (request_priority_level_i <= in_service_priority_i);
    case (svc_i)
      nia_pkg::NIA_IDLE:    accept_mask_o = mask_req_i & global_interrupt_enable_i;
      nia_pkg::NIA_SVC_MSK: accept_mask_o = mask_req_i & global_interrupt_enable_i & prio_ok;
      nia_pkg::NIA_SVC_SW:  accept_mask_o = mask_req_i & global_interrupt_enable_i;
      default:              accept_mask_o = 1'b0;
    endcase
    // Software requests ignore the enable flag and the servicing state.
    accept_sw_o = sw_req_i & ~accept_mask_o;
  end
endmodule : nia_judge
`default_nettype wire

/* File: nia_top.sv */
// Nested interrupt acceptance block with APB registers and interrupt output.
//
// What this block does
// - Servicing maskable at in-service 00: accept only level 0 maskable, only with enable.
// - In-service 01: accept maskable levels 0 and 1, only while enable is 1.
// - In-service 10: accept maskable levels 0, 1 and 2, only while enable is 1.
// - In-service 11: accept all maskable levels when enabled, none when disabled.
// - Servicing software interrupt: accept any maskable level when enabled, none otherwise.
`timescale 1ns/1ps
`default_nettype none
module nia_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Interrupt requests from peripherals (asynchronous levels)
  input  wire logic        mask_req_i,
  input  wire logic [1:0]  request_priority_level_i,
  input  wire logic        sw_req_i,
  // Processor core handshake
  input  wire logic        svc_done_i,
  output logic             take_mask_o,
  output logic             take_sw_o,
  output logic [1:0]       in_service_priority_o,
  // Interrupt line
  output logic             irq_o
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic       mreq_s;
  logic       sreq_s;
  logic [1:0] prio_s;

  // Each priority bit is synchronised on its own, so the priority must be set at
  // least two cycles before its request rises and held while the request stands.
  nia_sync u_sync_mreq (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .d_i(mask_req_i), .q_o(mreq_s));
  nia_sync u_sync_sreq (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .d_i(sw_req_i), .q_o(sreq_s));
  nia_sync u_sync_p0 (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
                      .d_i(request_priority_level_i[0]), .q_o(prio_s[0]));
  nia_sync u_sync_p1 (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
                      .d_i(request_priority_level_i[1]), .q_o(prio_s[1]));

  // ****************************************************************
  // Servicing state
  // ****************************************************************
  nia_pkg::nia_svc_t svc_q, svc_d;
  logic [1:0]        isp_q, isp_d;
  logic              ie_q, ie_d;
  logic              acc_m, acc_s;
  logic              take_m_d, take_s_d;

  nia_judge u_judge (
    .svc_i                     (svc_q),
    .in_service_priority_i     (isp_q),
    .global_interrupt_enable_i (ie_q),
    .mask_req_i                (mreq_s),
    .request_priority_level_i  (prio_s),
    .sw_req_i                  (sreq_s),
    .accept_mask_o             (acc_m),
    .accept_sw_o               (acc_s)
  );

  // Single-level nesting: completion returns to idle with the lowest
  // in-service level, so the core must save and restore deeper context.
  always_comb begin
    svc_d    = svc_q;
    isp_d    = isp_q;
    take_m_d = 1'b0;
    take_s_d = 1'b0;
    if (acc_m) begin
      svc_d    = nia_pkg::NIA_SVC_MSK;
      isp_d    = prio_s;
      take_m_d = 1'b1;
    end else if (acc_s) begin
      svc_d    = nia_pkg::NIA_SVC_SW;
      isp_d    = nia_pkg::RST_ISP;
      take_s_d = 1'b1;
    end else if (svc_done_i) begin
      svc_d = nia_pkg::NIA_IDLE;
      isp_d = nia_pkg::RST_ISP;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      svc_q       <= nia_pkg::NIA_IDLE;
      isp_q       <= nia_pkg::RST_ISP;
      take_mask_o <= 1'b0;
      take_sw_o   <= 1'b0;
    end else begin
      svc_q       <= svc_d;
      isp_q       <= isp_d;
      take_mask_o <= take_m_d;
      take_sw_o   <= take_s_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      in_service_priority_o <= nia_pkg::RST_ISP;
    end else begin
      in_service_priority_o <= isp_d;
    end
  end

  // ****************************************************************
  // APB registers and interrupt status
  // ****************************************************************
  logic [2:0]  stat_q, stat_d;
  logic [2:0]  mask_q, mask_d;
  logic [31:0] rdata_d;
  logic        wr_acc, rd_acc, hit, irq_d;
  logic [2:0]  ev, stat_clr;

  always_comb begin
    wr_acc  = psel_i & penable_i & pwrite_i;
    rd_acc  = psel_i & penable_i & ~pwrite_i;
    ie_d    = ie_q;
    mask_d  = mask_q;
    rdata_d = 32'h0000_0000;
    hit     = 1'b1;
    ev      = 3'h0;
    ev[nia_pkg::EV_ACC_BIT] = take_m_d;
    ev[nia_pkg::EV_REJ_BIT] = mreq_s & ~acc_m & ~take_mask_o;
    ev[nia_pkg::EV_SW_BIT]  = take_s_d;
    case (paddr_i)
      nia_pkg::ADDR_CTRL: begin
        rdata_d[nia_pkg::CTRL_IE_BIT] = ie_q;
        if (wr_acc) ie_d = pwdata_i[nia_pkg::CTRL_IE_BIT];
      end
      nia_pkg::ADDR_STATUS: rdata_d[2:0] = stat_q;
      nia_pkg::ADDR_MASK: begin
        rdata_d[2:0] = mask_q;
        if (wr_acc) mask_d = pwdata_i[2:0];
      end
      nia_pkg::ADDR_STATE: rdata_d[3:0] = {svc_q, isp_q};
      default: hit = 1'b0;
    endcase
    // A read clears only the bits that it returned, and an event in the same cycle
    // survives, so an event landing between the setup and access edges is kept.
    stat_clr = (rd_acc && paddr_i == nia_pkg::ADDR_STATUS) ? prdata_o[2:0] : 3'h0;
    stat_d   = (stat_q & ~stat_clr) | ev;
    irq_d  = |(stat_d & mask_d);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ie_q      <= nia_pkg::RST_IE;
      mask_q    <= nia_pkg::RST_MASK;
      stat_q    <= 3'h0;
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      irq_o     <= 1'b0;
    end else begin
      ie_q      <= ie_d;
      mask_q    <= mask_d;
      stat_q    <= stat_d;
      prdata_o  <= rdata_d;
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~hit;
      irq_o     <= irq_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_lvl0_only;
    @(posedge clk_i) disable iff (sys_rst_i)
      (svc_q == nia_pkg::NIA_SVC_MSK && isp_q == 2'h0 && acc_m) |-> (prio_s == 2'h0 && ie_q);
  endproperty
  a_lvl0_only: assert property (p_lvl0_only) else $error("nested accept above level 0");

  property p_isp01;
    @(posedge clk_i) disable iff (sys_rst_i)
      (svc_q == nia_pkg::NIA_SVC_MSK && isp_q == 2'h1 && mreq_s && ie_q && prio_s <= 2'h1)
      |-> acc_m;
  endproperty
  a_isp01: assert property (p_isp01) else $error("level 0/1 not accepted at 01");

  property p_isp10;
    @(posedge clk_i) disable iff (sys_rst_i)
      (svc_q == nia_pkg::NIA_SVC_MSK && isp_q == 2'h2 && mreq_s)
      |-> (acc_m == (ie_q && prio_s != nia_pkg::PRIO_LVL3));
  endproperty
  a_isp10: assert property (p_isp10) else $error("wrong decision at 10");

  property p_isp11;
    @(posedge clk_i) disable iff (sys_rst_i)
      (svc_q == nia_pkg::NIA_SVC_MSK && isp_q == 2'h3 && mreq_s) |-> (acc_m == ie_q);
  endproperty
  a_isp11: assert property (p_isp11) else $error("wrong decision at 11");

  property p_sw_svc;
    @(posedge clk_i) disable iff (sys_rst_i)
      (svc_q == nia_pkg::NIA_SVC_SW && mreq_s) |=> (take_mask_o == $past(ie_q));
  endproperty
  a_sw_svc: assert property (p_sw_svc) else $error("wrong decision in sw service");

  property p_sw_accept;
    @(posedge clk_i) disable iff (sys_rst_i)
      (sreq_s && !acc_m) |=> take_sw_o ##0 svc_q == nia_pkg::NIA_SVC_SW;
  endproperty
  a_sw_accept: assert property (p_sw_accept) else $error("software request dropped");

  property p_isp_load;
    @(posedge clk_i) disable iff (sys_rst_i)
      acc_m |=> (isp_q == $past(prio_s) && in_service_priority_o == isp_q);
  endproperty
  a_isp_load: assert property (p_isp_load) else $error("in-service level not loaded");

  property p_ie_gate;
    @(posedge clk_i) disable iff (sys_rst_i)
      !ie_q |-> !acc_m;
  endproperty
  a_ie_gate: assert property (p_ie_gate) else $error("accept while disabled");

  property p_take_excl;
    @(posedge clk_i) disable iff (sys_rst_i)
      !(take_mask_o && take_sw_o);
  endproperty
  a_take_excl: assert property (p_take_excl) else $error("both requests taken at once");

  property p_sw_no_ie;
    @(posedge clk_i) disable iff (sys_rst_i)
      (sreq_s && !mreq_s && !ie_q) |=> take_sw_o;
  endproperty
  a_sw_no_ie: assert property (p_sw_no_ie) else $error("software request gated by enable");

  property p_isp_out;
    @(posedge clk_i) disable iff (sys_rst_i)
      in_service_priority_o == isp_q;
  endproperty
  a_isp_out: assert property (p_isp_out) else $error("in-service output differs");

  property p_done_idle;
    @(posedge clk_i) disable iff (sys_rst_i)
      (svc_done_i && !acc_m && !acc_s)
      |=> (svc_q == nia_pkg::NIA_IDLE && isp_q == nia_pkg::RST_ISP);
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("service end not taken");

  // ****************************************************************
  // Bus and status checks
  // ****************************************************************
  // No rule names these, but software relies on the handshake and on
  // sticky status bits that only a read of the status register clears.
  property p_ready_pulse;
    @(posedge clk_i) disable iff (sys_rst_i)
      (psel_i && !penable_i) |=> (pready_o ##1 !pready_o);
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready not a single pulse");

  property p_err_ready;
    @(posedge clk_i) disable iff (sys_rst_i)
      pslverr_o |-> pready_o;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");

  property p_rej_flag;
    @(posedge clk_i) disable iff (sys_rst_i)
      (mreq_s && !acc_m && !take_mask_o) |=> stat_q[nia_pkg::EV_REJ_BIT];
  endproperty
  a_rej_flag: assert property (p_rej_flag) else $error("rejection not recorded");

  property p_stat_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
      (stat_q[nia_pkg::EV_ACC_BIT] && !(rd_acc && paddr_i == nia_pkg::ADDR_STATUS))
      |=> stat_q[nia_pkg::EV_ACC_BIT];
  endproperty
  a_stat_hold: assert property (p_stat_hold) else $error("status bit lost without a read");

  property p_irq_level;
    @(posedge clk_i) disable iff (sys_rst_i)
      irq_o == |(stat_q & mask_q);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt line differs from status");

  // ****************************************************************
  // Cover points
  // ****************************************************************
  c_nest:  cover property (@(posedge clk_i) svc_q == nia_pkg::NIA_SVC_MSK ##1 take_mask_o);
  c_sw:    cover property (@(posedge clk_i) take_sw_o);
  c_irq:   cover property (@(posedge clk_i) irq_o);
  c_rej:   cover property (@(posedge clk_i) stat_q[nia_pkg::EV_REJ_BIT]);
  c_swnest: cover property (@(posedge clk_i) svc_q == nia_pkg::NIA_SVC_SW ##1 take_mask_o);

endmodule : nia_top
`default_nettype wire

/* File: nia_core_model.sv */
// Behavioural model of the core that ends a service on request.
`timescale 1ns/1ps
`default_nettype none
module nia_core_model #(
  parameter int LAT = 2
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // Bench control
  input  wire logic release_i,
  // Handshake
  output logic      svc_done_o
);
  // ****************
  // Service end
  // ****************
  logic       rel_q;
  logic [3:0] cnt_q;
  always_ff @(posedge clk_i) begin
    rel_q      <= release_i;
    svc_done_o <= 1'b0;
    if (sys_rst_i) begin
      cnt_q <= 4'h0;
    end else if (release_i && !rel_q) begin
      cnt_q <= 4'(LAT);
    end else if (cnt_q != 4'h0) begin
      cnt_q      <= cnt_q - 4'h1;
      svc_done_o <= (cnt_q == 4'h1);
    end
  end
endmodule : nia_core_model
`default_nettype wire

/* File: nested_interrupt_acceptance_tb.sv */
// Self-checking testbench for the nested interrupt acceptance block.
`timescale 1ns/1ps
`default_nettype none
module nested_interrupt_acceptance_tb;
  // ****************
  // Wiring
  // ****************
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, rel = 1'b0;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic        pready_o, pslverr_o, mask_req_i = 1'b0, sw_req_i = 1'b0, er, acc, irq_s;
  logic [1:0]  request_priority_level_i = 2'h0, in_service_priority_o, isp_s;
  logic        svc_done_i, take_mask_o, take_sw_o, irq_o;
  int          fail_count = 0, total_checks = 0, cyc = 0;
  always #2.5 clk_i = ~clk_i;
  nia_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .mask_req_i(mask_req_i),
    .request_priority_level_i(request_priority_level_i), .sw_req_i(sw_req_i),
    .svc_done_i(svc_done_i), .take_mask_o(take_mask_o), .take_sw_o(take_sw_o),
    .in_service_priority_o(in_service_priority_o), .irq_o(irq_o));
  nia_core_model #(.LAT(2)) core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .release_i(rel),
    .svc_done_o(svc_done_i));
  // ****************
  // Shared tasks
  // ****************
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task apb(input logic [11:0] ad, input logic w, input logic [31:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // The request stands until ready is seen high at a rising edge; data is taken there.
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  task samp;
    @(negedge clk_i);
    isp_s = in_service_priority_o;
    irq_s = irq_o;
    @(posedge clk_i);
  endtask : samp
  // Requests are held for six cycles, not dropped on take; the extra takes this causes are harmless.
  task try_req(input logic sw, input logic [1:0] p);
    acc = 1'b0;
    // The priority settles through its synchronisers before the request rises.
    request_priority_level_i <= p;
    repeat (2) @(posedge clk_i);
    if (sw) sw_req_i <= 1'b1;
    else mask_req_i <= 1'b1;
    repeat (6) begin
      @(negedge clk_i);
      if ((sw ? take_sw_o : take_mask_o) === 1'b1) acc = 1'b1;
    end
    @(posedge clk_i);
    mask_req_i <= 1'b0;
    sw_req_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    samp();
  endtask : try_req
  task go_idle;
    rel <= 1'b1;
    @(posedge clk_i);
    rel <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask : go_idle
  // ****************
  // Scenarios
  // ****************
  task test_reset;
    samp();
    chk("in-service", 32'h3, 32'(isp_s));
    chk("irq", 32'h0, 32'(irq_s));
    apb(nia_pkg::ADDR_CTRL, 1'b0, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(nia_pkg::ADDR_STATE, 1'b0, 32'h0);
    chk("state", 32'h3, rd);
    apb(12'h010, 1'b0, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], er});
  endtask : test_reset
  task test_nest;
    logic ex;
    for (int l = 0; l < 4; l++)
      for (int p = 0; p < 4; p++)
        for (int ie = 0; ie < 2; ie++) begin
          apb(nia_pkg::ADDR_CTRL, 1'b1, 32'h1);
          try_req(1'b0, 2'(l));
          apb(nia_pkg::ADDR_CTRL, 1'b1, 32'(ie));
          try_req(1'b0, 2'(p));
          ex = (ie == 1) && (p <= l);
          chk("nested take", 32'(ex), 32'(acc));
          chk("in-service", ex ? 32'(p) : 32'(l), 32'(isp_s));
          if (ie == 0) begin
            try_req(1'b1, 2'h0);
            chk("sw take", 32'h1, 32'(acc));
          end
          go_idle();
        end
  endtask : test_nest
  task test_sw;
    for (int ie = 0; ie < 2; ie++)
      for (int p = 0; p < 4; p++) begin
        apb(nia_pkg::ADDR_CTRL, 1'b1, 32'(ie));
        try_req(1'b1, 2'h0);
        chk("sw take", 32'h1, 32'(acc));
        apb(nia_pkg::ADDR_STATE, 1'b0, 32'h0);
        chk("state", 32'hB, rd);
        try_req(1'b0, 2'(p));
        chk("take in sw", 32'(ie), 32'(acc));
        go_idle();
      end
  endtask : test_sw
  task test_irq;
    apb(nia_pkg::ADDR_CTRL, 1'b1, 32'h0);
    apb(nia_pkg::ADDR_STATUS, 1'b0, 32'h0);
    apb(nia_pkg::ADDR_MASK, 1'b1, 32'h2);
    try_req(1'b1, 2'h0);
    try_req(1'b0, 2'h0);
    chk("irq", 32'h1, 32'(irq_s));
    apb(nia_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("status", 32'h6, rd);
    samp();
    chk("irq", 32'h0, 32'(irq_s));
    apb(nia_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("status", 32'h0, rd);
    apb(nia_pkg::ADDR_MASK, 1'b1, 32'h0);
    try_req(1'b0, 2'h3);
    chk("irq", 32'h0, 32'(irq_s));
    apb(nia_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("status", 32'h2, rd);
    apb(nia_pkg::ADDR_CTRL, 1'b1, 32'h1);
    apb(nia_pkg::ADDR_MASK, 1'b1, 32'h1);
    try_req(1'b0, 2'h2);
    chk("take in sw", 32'h1, 32'(acc));
    chk("irq", 32'h1, 32'(irq_s));
    apb(nia_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("status", 32'h1, rd);
    go_idle();
  endtask : test_irq
  task test_rerst;
    try_req(1'b0, 2'h1);
    chk("in-service", 32'h1, 32'(isp_s));
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    samp();
    chk("in-service", 32'h3, 32'(isp_s));
    chk("irq", 32'h0, 32'(irq_s));
    apb(nia_pkg::ADDR_CTRL, 1'b0, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(nia_pkg::ADDR_STATE, 1'b0, 32'h0);
    chk("state", 32'h3, rd);
  endtask : test_rerst
  // ****************
  // Run control
  // ****************
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    test_reset();
    test_nest();
    test_sw();
    test_irq();
    test_rerst();
    finish_test();
  end
endmodule : nested_interrupt_acceptance_tb
`default_nettype wire
